//--- gpj_port.sv
// top of an eight-pin general-purpose port with memory bus override.
// assumes pad levels arrive asynchronously; registers sit on a plain
// strobe port clocked by clk with read data one cycle after the strobe.
//
// Local design decisions: the address map and strobed register access.
`default_nettype none
module gpj_port
  import gpj_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [gpj_pkg::GPJ_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // memory interface strobes
  input wire logic address_latch_enable,
  input wire logic output_enable,
  input wire logic write_low_strobe,
  input wire logic write_high_strobe,
  input wire logic byte_access_zero,
  input wire logic chip_enable,
  input wire logic lower_byte_select,
  input wire logic upper_byte_select,
  // pads
  input wire logic [gpj_pkg::GPJ_W-1:0] pad_in,
  output logic [gpj_pkg::GPJ_W-1:0] pad_out,
  output logic [gpj_pkg::GPJ_W-1:0] pad_oe,
  output logic [gpj_pkg::GPJ_W-1:0] pad_pullup,
  // lcd segment select per pin, and memory bus enable status
  output logic [gpj_pkg::GPJ_W-1:0] lcd_seg_sel,
  output logic membus_active
);
  import gpj_pkg::*;
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] latch_ff; // port_output_latch_reg
  logic [7:0] dir_ff; // port_direction_reg
  logic [7:0] memctl_ff; // memory_interface_control_reg
  logic [7:0] pad_configuration_reg_ff; // pad_configuration_reg
  logic [7:0] lcdseg_ff; // segment enable per pin
  logic [7:0] rdata_ff; // read data, valid the cycle after reg_rd
  logic [7:0] nxt_rdata;
  logic [7:0] pin_sync; // synchronised pad levels
  gpj_reg_t wr_sel;
  // ****************************************************************
  // write address decode
  // ****************************************************************
  assign wr_sel = !reg_wr ? GPJ_REG_NONE :
    (reg_addr == GPJ_OFS_PIN_DATA) ? GPJ_REG_LATCH :
    (reg_addr == GPJ_OFS_LATCH) ? GPJ_REG_LATCH :
    (reg_addr == GPJ_OFS_DIR) ? GPJ_REG_DIR :
    (reg_addr == GPJ_OFS_MEMCTL) ? GPJ_REG_MEMCTL :
    (reg_addr == GPJ_OFS_PAD_CONFIGURATION_REG) ? GPJ_REG_PAD_CONFIGURATION_REG :
    (reg_addr == GPJ_OFS_LCDSEG) ? GPJ_REG_LCDSEG : GPJ_REG_NONE;
  // ****************************************************************
  // control registers
  // ****************************************************************
  // reset makes every pin an input and turns pull-ups off
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      latch_ff <= GPJ_RST_LATCH;
      dir_ff <= GPJ_RST_DIR;
      memctl_ff <= GPJ_RST_MEMCTL;
      pad_configuration_reg_ff <= GPJ_RST_PAD_CONFIGURATION_REG;
      lcdseg_ff <= GPJ_RST_LCDSEG;
    end
    else
    begin
      case (wr_sel)
        GPJ_REG_LATCH: latch_ff <= reg_wdata;
        GPJ_REG_DIR: dir_ff <= reg_wdata;
        GPJ_REG_MEMCTL: memctl_ff <= reg_wdata;
        GPJ_REG_PAD_CONFIGURATION_REG: pad_configuration_reg_ff <= reg_wdata;
        GPJ_REG_LCDSEG: lcdseg_ff <= reg_wdata;
        default: latch_ff <= latch_ff;
      endcase
    end
  end
  // ****************************************************************
  // read path
  // ****************************************************************
  // unmapped offsets read as zero; data register shows the pins
  assign nxt_rdata = !reg_rd ? 8'h00 :
    (reg_addr == GPJ_OFS_PIN_DATA) ? pin_sync :
    (reg_addr == GPJ_OFS_LATCH) ? latch_ff :
    (reg_addr == GPJ_OFS_DIR) ? dir_ff :
    (reg_addr == GPJ_OFS_MEMCTL) ? memctl_ff :
    (reg_addr == GPJ_OFS_PAD_CONFIGURATION_REG) ? pad_configuration_reg_ff :
    (reg_addr == GPJ_OFS_LCDSEG) ? lcdseg_ff : 8'h00;
  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata = rdata_ff;
  // ****************************************************************
  // pin functions
  // ****************************************************************
  // bus owns every pin not taken by an lcd segment while its disable bit is clear
  assign membus_active = ~memctl_ff[GPJ_MEMBUS_DISABLE_BIT];
  // strobes listed from pin 7 down to pin 0
  wire [7:0] bus_vals = {upper_byte_select, lower_byte_select,
    chip_enable, byte_access_zero, write_high_strobe,
    write_low_strobe, output_enable, address_latch_enable};
  wire pullup_glob = pad_configuration_reg_ff[GPJ_PULLUP_ENABLE_BIT];
  // one synchroniser and one mux per pin
  for (genvar i = 0; i < GPJ_W; i++)
  begin : g_pin
    gpj_sync_bit u_sync (
      .clk(clk),
      .rst(rst),
      .async_in(pad_in[i]),
      .sync_out(pin_sync[i])
    );
    gpj_pad_mux u_mux (
      .lcd_en(lcdseg_ff[i]),
      .membus_en(membus_active),
      .membus_val(bus_vals[i]),
      .dir_in(dir_ff[i]),
      .latch_val(latch_ff[i]),
      .pullup_glob(pullup_glob),
      .pad_out(pad_out[i]),
      .pad_oe(pad_oe[i]),
      .pad_pullup(pad_pullup[i]),
      .lcd_sel(lcd_seg_sel[i])
    );
  end
endmodule
`default_nettype wire

//--- gpj_pkg.sv
// package for the general-purpose port block: register indices, field
// positions, reset values and widths shared by the design files.
// assumes a single clock domain and a plain strobe-based register port.
`default_nettype none
package gpj_pkg;
  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int GPJ_W = 8; // pins in the port
  localparam int GPJ_AW = 4; // register address width
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [3:0] GPJ_OFS_PIN_DATA = 4'h0; // port_pin_data_reg
  localparam logic [3:0] GPJ_OFS_LATCH = 4'h1; // port_output_latch_reg
  localparam logic [3:0] GPJ_OFS_DIR = 4'h2; // port_direction_reg
  localparam logic [3:0] GPJ_OFS_MEMCTL = 4'h3; // memory_interface_control
  localparam logic [3:0] GPJ_OFS_PAD_CONFIGURATION_REG = 4'h4; // pad_configuration_reg
  localparam logic [3:0] GPJ_OFS_LCDSEG = 4'h5; // per-pin segment enables
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int GPJ_MEMBUS_DISABLE_BIT = 7; // membus_disable_bit
  localparam int GPJ_PULLUP_ENABLE_BIT = 2; // port_pullup_enable_bit
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] GPJ_RST_LATCH = 8'h00;
  localparam logic [7:0] GPJ_RST_DIR = 8'hFF; // all inputs
  localparam logic [7:0] GPJ_RST_MEMCTL = 8'h80; // memory bus disabled
  localparam logic [7:0] GPJ_RST_PAD_CONFIGURATION_REG = 8'h00; // pull-ups off
  localparam logic [7:0] GPJ_RST_LCDSEG = 8'h00;
  localparam logic [1:0] GPJ_RST_SYNC = 2'h0;
  // ****************************************************************
  // register ids for the write decoder
  // ****************************************************************
  typedef enum logic [2:0] {
    GPJ_REG_NONE = 3'b000,
    GPJ_REG_LATCH = 3'b001,
    GPJ_REG_DIR = 3'b010,
    GPJ_REG_MEMCTL = 3'b011,
    GPJ_REG_PAD_CONFIGURATION_REG = 3'b100,
    GPJ_REG_LCDSEG = 3'b101
  } gpj_reg_t;
endpackage
`default_nettype wire

//--- gpj_sync_bit.sv
// two-flop synchroniser for one pad input bit.
// assumes the pad level is asynchronous to clk.
`default_nettype none
module gpj_sync_bit
  import gpj_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // async level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);
  // stage 0 feeds only stage 1; nothing else may look at it
  logic [1:0] sync_ff;
  // ****************************************************************
  // shift register
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_ff <= GPJ_RST_SYNC;
    end
    else
    begin
      sync_ff <= {sync_ff[0], async_in};
    end
  end
  assign sync_out = sync_ff[1];
endmodule
`default_nettype wire

//--- gpj_pad_mux.sv
// per-pin function selection: lcd segment beats memory bus beats gpio.
// assumes the inputs other than membus_val are registered values from the port top.
`default_nettype none
module gpj_pad_mux
  import gpj_pkg::*;
(
  // per-pin controls
  input wire logic lcd_en,
  input wire logic membus_en,
  input wire logic membus_val,
  input wire logic dir_in,
  input wire logic latch_val,
  input wire logic pullup_glob,
  // pad drive
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pullup,
  output logic lcd_sel
);
  // gpio drives when its direction bit is zero
  wire gpio_drive = ~dir_in;
  // memory bus ignores the direction bit and drives unless lcd_en takes the pin
  wire bus_drive = membus_en & ~lcd_en;
  // ****************************************************************
  // selection
  // ****************************************************************
  assign lcd_sel = lcd_en;
  assign pad_oe = ~lcd_en & (membus_en | gpio_drive);
  assign pad_out = lcd_en ? 1'b0 :
                   (bus_drive ? membus_val : latch_val);
  // pull-up only on a digital input pin with the global enable set
  assign pad_pullup = pullup_glob & ~pad_oe & ~lcd_en;
endmodule
`default_nettype wire

//--- gpj_port_sva.sv
// checker bound into gpj_port: pin mux and register write effects.
// assumes one clock domain and the port names of gpj_port.
`default_nettype none
module gpj_port_sva
  import gpj_pkg::*;
(
  input wire logic clk, rst, reg_wr, reg_rd, membus_active,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata, pad_out, pad_oe,
  input wire logic [7:0] pad_pullup, lcd_seg_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_po; (pad_pullup & pad_oe) == 8'h00; endproperty
  a_po: assert property (p_po) else $error("pull-up on output");
  property p_lcd; (lcd_seg_sel & (pad_oe | pad_pullup)) == 8'h00;
  endproperty
  a_lcd: assert property (p_lcd) else $error("lcd pin in use");
  property p_boe; membus_active |-> (pad_oe | lcd_seg_sel) == 8'hFF;
  endproperty
  a_boe: assert property (p_boe) else $error("bus pin idle");
  property p_mc; reg_wr && reg_addr == GPJ_OFS_MEMCTL |=>
    membus_active == !$past(reg_wdata[7]); endproperty
  a_mc: assert property (p_mc) else $error("bus enable wrong");
  property p_dir; reg_wr && reg_addr == GPJ_OFS_DIR |=> membus_active ||
    ((pad_oe ^ ~$past(reg_wdata)) & ~lcd_seg_sel) == 8'h00; endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_lat; reg_wr && reg_addr <= GPJ_OFS_LATCH |=> membus_active ||
    ((pad_out ^ $past(reg_wdata)) & pad_oe) == 8'h00; endproperty
  a_lat: assert property (p_lat) else $error("latch not out");
  property p_pu; reg_wr && reg_addr == GPJ_OFS_PAD_CONFIGURATION_REG && !reg_wdata[2] |=>
    pad_pullup == 8'h00; endproperty
  a_pu: assert property (p_pu) else $error("pull-up still on");
  property p_rd; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data not idle");
endmodule
bind gpj_port gpj_port_sva u_sva (.*);
`default_nettype wire

//--- gpj_mem_model.sv
// pad-side partner: the far side drives every pin the port leaves free.
// assumes it never fights a pin that the port itself drives.
`default_nettype none
module gpj_mem_model
(
  input wire logic [7:0] pad_out, pad_oe, ext_val,
  output logic [7:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule
`default_nettype wire

//--- testbench.sv
// bench for gpj_port: register port, pin levels, bus and lcd takeover.
// assumes gpj_pkg, gpj_port and gpj_mem_model are compiled first.
`default_nettype none
module testbench;
  import gpj_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, mba;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, bus = 8'h00, ext = 8'h00, q, rdat, pin;
  logic [7:0] pout, poe, ppu, lsel;
  int bad_count = 0, cmp_count = 0;
  always #4 clk = ~clk;
  gpj_port DUT (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .pad_in(pin),
    .address_latch_enable(bus[0]), .output_enable(bus[1]),
    .write_low_strobe(bus[2]), .write_high_strobe(bus[3]),
    .byte_access_zero(bus[4]), .chip_enable(bus[5]),
    .lower_byte_select(bus[6]), .upper_byte_select(bus[7]), .pad_out(pout),
    .pad_oe(poe), .pad_pullup(ppu), .lcd_seg_sel(lsel), .membus_active(mba));
  gpj_mem_model u_mem (.pad_out(pout), .pad_oe(poe), .ext_val(ext),
    .pad_in(pin));
  task automatic chk(string n, logic [7:0] g, logic [7:0] e);
    cmp_count++;
    bad_count += int'(g !== e);
    if (g !== e) $display("[FAIL] %s exp %h got %h", n, e, g);
  endtask
  // one register access; read data is caught in q
  task automatic acc(logic w, logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    {wr, rd, addr, wd} <= {w, !w, a, d};
    @(posedge clk);
    {wr, rd} <= 2'b00;
    #1 q = rdat;
  endtask
  task automatic stop_test(int extra);
    bad_count += extra;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_cfg;
    chk("oe", poe, 8'h00);
    chk("pu", ppu, 8'h00);
    acc(1, GPJ_OFS_PIN_DATA, 8'h5A);
    acc(1, GPJ_OFS_DIR, 8'hCF);
    chk("oe", poe, 8'h30);
    chk("out", pout & poe, 8'h10);
    acc(0, GPJ_OFS_LATCH, 8'h00);
    chk("lat", q, 8'h5A);
    acc(1, GPJ_OFS_PAD_CONFIGURATION_REG, 8'h04);
    chk("pu", ppu, 8'hCF);
    acc(1, GPJ_OFS_PAD_CONFIGURATION_REG, 8'h00);
    chk("pu", ppu, 8'h00);
  endtask
  // inputs show the far side, outputs their own latch
  task automatic t_pin;
    ext <= 8'h3C;
    acc(0, GPJ_OFS_PIN_DATA, 8'h00);
    acc(0, GPJ_OFS_PIN_DATA, 8'h00);
    chk("pin", q, 8'h1C);
    acc(0, 4'hF, 8'h00);
    chk("gap", q, 8'h00);
  endtask
  task automatic t_bus;
    acc(1, GPJ_OFS_MEMCTL, 8'h00);
    chk("mb", 8'(mba), 8'h01);
    chk("oe", poe, 8'hFF);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk) bus <= 8'h01 << i;
      #1 chk("map", pout, 8'h01 << i);
    end
    acc(1, GPJ_OFS_LCDSEG, 8'h81);
    chk("lcd", lsel, 8'h81);
    chk("oe", poe, 8'h7E);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1 t_cfg;
    t_pin;
    t_bus;
    stop_test(0);
  end
  initial #100000 stop_test(1);
endmodule
`default_nettype wire
